/* File: design/tc_pkg.sv */
// Constants, field layout and state types for the three timer/counter units
package tc_pkg;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int unsigned OSC_PER_MC = 12;
   localparam int unsigned PRESC_W = 4;
   localparam logic [PRESC_W-1:0] MC_LAST = PRESC_W'(OSC_PER_MC - 1);
   localparam logic [PRESC_W-1:0] PRESC_ONE = 4'h1;

   // -----------------------------------------------------------------
   // Counts and units
   // -----------------------------------------------------------------
   localparam int unsigned UNITS = 3;
   localparam int unsigned UNIT_C = 2;
   localparam logic [15:0] CNT_RST = 16'h0000;
   localparam logic [15:0] CNT_ONES = 16'hFFFF;
   localparam logic [15:0] CNT_ONE = 16'h0001;

   // -----------------------------------------------------------------
   // Register map (byte offsets) and field positions
   // -----------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] COUNT_A_OFS = 8'h04;
   localparam logic [7:0] COUNT_B_OFS = 8'h08;
   localparam logic [7:0] COUNT_C_OFS = 8'h0C;
   localparam logic [7:0] RELOAD_OFS = 8'h10;
   localparam logic [7:0] CAPTURE_OFS = 8'h14;
   localparam logic [7:0] STATUS_OFS = 8'h18;
   localparam logic [7:0] MASK_OFS = 8'h1C;
   localparam int unsigned RUN_LSB = 0;
   localparam int unsigned EVT_LSB = 4;
   localparam int unsigned MODE_LSB = 8;
   localparam int unsigned DOWN_BIT = 10;
   localparam int unsigned STAT_W = 4;
   localparam int unsigned CAPT_BIT = 3;
   localparam logic [1:0] MODE_PLAIN = 2'h0;
   localparam logic [1:0] MODE_CAPTURE = 2'h1;
   localparam logic [1:0] MODE_RELOAD = 2'h2;
   localparam logic [1:0] MODE_OUTPUT = 2'h3;

   // -----------------------------------------------------------------
   // State carriers
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [2:0] sync;
      logic filt;
      logic smp;
      logic pend;
      logic pulse;
   } sampler_s;

   typedef struct packed {
      logic [PRESC_W-1:0] presc;
      logic tick;
      logic [UNITS-1:0] run;
      logic [UNITS-1:0] evt;
      logic [1:0] mode_c;
      logic down_c;
      logic [UNITS-1:0][15:0] cnt;
      logic [15:0] reload;
      logic [15:0] capt;
      logic [STAT_W-1:0] status;
      logic [STAT_W-1:0] mask;
      logic tout;
      logic wr_pend;
      logic [7:0] wr_ofs;
      logic [31:0] rdata;
   } core_s;

endpackage

/* File: design/event_sampler.sv */
// Event input synchroniser and machine-cycle falling edge detector
`timescale 1ns/1ps
`default_nettype none
module event_sampler
   import tc_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic pin,
   input wire logic mc_tick,
   output logic count_pulse
);

   sampler_s q;
   sampler_s d;

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   // Level accepted only when the last two sync stages agree
   always_comb begin
      d = q;
      d.sync = {q.sync[1:0], pin};
      if (q.sync[1] == q.sync[2]) begin
         d.filt = q.sync[2];
      end
      d.pulse = 1'b0;
      if (mc_tick) begin
         d.smp = q.filt; // One sample per machine cycle
         d.pend = q.smp && !q.filt; // High then low is one edge
         d.pulse = q.pend; // Count lands one machine cycle later
      end
   end

   // Low reset levels avoid a false edge from a pin held low at reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign count_pulse = q.pulse;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   sequence fall_seen_s;
      mc_tick && q.smp && !q.filt;
   endsequence

   sequence one_mc_later_s;
      (!q.pulse)[*8] ##4 !q.pulse ##1 q.pulse;
   endsequence

   property edge_to_count_p;
      @(posedge hclk) disable iff (!hresetn) fall_seen_s |-> ##1 one_mc_later_s;
   endproperty

   edge_count_lat_a: assert property (edge_to_count_p)
      else $error("falling edge did not yield a count one machine cycle later");

   count_rate_a: assert property (@(posedge hclk) disable iff (!hresetn)
      q.pulse |=> (!q.pulse)[*8])
      else $error("event counts closer than one machine cycle");

   sample_tick_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !mc_tick |=> $stable(q.smp))
      else $error("event sample changed outside a machine cycle tick");

endmodule
`default_nettype wire

/* File: design/timer_counters.sv */
// Three 16-bit timer/counter units with an AHB-Lite register slave
//
// Chosen here: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module timer_counters
   import tc_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic event_input_a,
   input wire logic event_input_b,
   input wire logic event_input_c,
   output logic timer_out,
   output logic irq
);

   core_s q;
   core_s d;
   logic [UNITS-1:0] pulse;
   logic [UNITS-1:0] pins;

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   // Increment with carry out, shared by all three units
   function automatic logic [16:0] inc16(input logic [15:0] v);
      inc16 = {1'b0, v} + {1'b0, CNT_ONE};
   endfunction

   // ------------------------------------------------------------------
   // Event inputs
   // ------------------------------------------------------------------
   assign pins = {event_input_c, event_input_b, event_input_a};

   // Each unit has its own dedicated pin and sampler
   for (genvar g = 0; g < UNITS; g++) begin : g_smp
      event_sampler u_smp (
         .hclk(hclk),
         .hresetn(hresetn),
         .pin(pins[g]),
         .mc_tick(q.tick),
         .count_pulse(pulse[g])
      );
   end

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      logic acc;
      logic mapped;
      logic rclr;
      logic stp;
      logic ovf;
      logic reloadish;
      logic [16:0] nx;
      logic [STAT_W-1:0] ev;
      logic [31:0] r;
      acc = 1'b0;
      mapped = 1'b0;
      rclr = 1'b0;
      stp = 1'b0;
      ovf = 1'b0;
      reloadish = 1'b0;
      nx = '0;
      ev = '0;
      r = '0;
      d = q;

      // Machine cycle is twelve oscillator periods
      d.tick = (q.presc == MC_LAST);
      d.presc = (q.presc == MC_LAST) ? '0 : q.presc + PRESC_ONE;

      // Units a and b: plain 16-bit timer or event counter
      // They never reload, they simply wrap past all ones
      for (int u = 0; u < UNIT_C; u++) begin
         stp = q.evt[u] ? pulse[u] : q.tick; // Edges or machine cycles
         if (q.run[u] && stp) begin
            nx = inc16(q.cnt[u]);
            d.cnt[u] = nx[15:0]; // All ones wraps to zero
            ev[u] = nx[16]; // Overflow requests the interrupt
         end
      end

      // Unit c: capture uses its pin as trigger, so it times machine cycles then
      reloadish = (q.mode_c == MODE_RELOAD) || (q.mode_c == MODE_OUTPUT);
      stp = (q.evt[UNIT_C] && q.mode_c != MODE_CAPTURE) ? pulse[UNIT_C] : q.tick;
      // Capture ignores run, so a stopped unit c still records pin edges
      if (q.mode_c == MODE_CAPTURE && pulse[UNIT_C]) begin
         d.capt = q.cnt[UNIT_C]; // Snapshot of the count
         ev[CAPT_BIT] = 1'b1;
      end
      if (q.run[UNIT_C] && stp) begin
         if (reloadish && q.down_c) begin
            // Down count underflows once it reaches the reload value
            ovf = (q.cnt[UNIT_C] == q.reload);
            d.cnt[UNIT_C] = ovf ? CNT_ONES : q.cnt[UNIT_C] - CNT_ONE;
         end else begin
            nx = inc16(q.cnt[UNIT_C]);
            ovf = nx[16];
            d.cnt[UNIT_C] = (ovf && reloadish) ? q.reload : nx[15:0];
         end
         ev[UNIT_C] = ovf;
         if (ovf && q.mode_c == MODE_OUTPUT) begin
            d.tout = ~q.tout; // Output toggles on every rollover
         end
      end

      // Bus address phase: read data are latched here for the data phase
      acc = hsel && htrans[1] && hready;
      mapped = (haddr[31:8] == '0);
      d.wr_pend = acc && hwrite && mapped;
      d.wr_ofs = haddr[7:0];
      if (acc && !hwrite) begin
         if (mapped) begin
            unique case (haddr[7:0])
               CTRL_OFS: begin
                  r[RUN_LSB +: UNITS] = q.run;
                  r[EVT_LSB +: UNITS] = q.evt;
                  r[MODE_LSB +: 2] = q.mode_c;
                  r[DOWN_BIT] = q.down_c;
               end
               COUNT_A_OFS: r[15:0] = q.cnt[0];
               COUNT_B_OFS: r[15:0] = q.cnt[1];
               COUNT_C_OFS: r[15:0] = q.cnt[UNIT_C];
               RELOAD_OFS: r[15:0] = q.reload;
               CAPTURE_OFS: r[15:0] = q.capt;
               STATUS_OFS: begin
                  r[STAT_W-1:0] = q.status;
                  rclr = 1'b1;
               end
               MASK_OFS: r[STAT_W-1:0] = q.mask;
               default: r = '0;
            endcase
         end
         d.rdata = r;
      end

      // Flags are sticky until software reads the status word
      // Read clears the flags, but an event in the same cycle still lands
      d.status = (rclr ? '0 : q.status) | ev;

      // Bus data phase: a software write beats a count step in that cycle
      if (q.wr_pend) begin
         unique case (q.wr_ofs)
            CTRL_OFS: begin
               d.run = hwdata[RUN_LSB +: UNITS];
               d.evt = hwdata[EVT_LSB +: UNITS];
               d.mode_c = hwdata[MODE_LSB +: 2];
               d.down_c = hwdata[DOWN_BIT];
            end
            COUNT_A_OFS: d.cnt[0] = hwdata[15:0];
            COUNT_B_OFS: d.cnt[1] = hwdata[15:0];
            COUNT_C_OFS: d.cnt[UNIT_C] = hwdata[15:0];
            RELOAD_OFS: d.reload = hwdata[15:0];
            MASK_OFS: d.mask = hwdata[STAT_W-1:0];
            default: d.mask = q.mask;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // State register
   // ------------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // Zero wait states keep the slave simple; every answer is OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = q.rdata;
   assign timer_out = q.tout;
   assign irq = |(q.status & q.mask); // Level while an unmasked flag stands

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   // Every check runs on hclk and sleeps while reset is asserted
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   sequence timer_step_a_s;
      q.tick && q.run[0] && !q.evt[0] && !q.wr_pend;
   endsequence

   mc_period_a: assert property (q.tick |-> ##1 !q.tick ##11 q.tick)
      else $error("machine cycle tick not every twelve clocks");

   timer_inc_a: assert property (timer_step_a_s ##0 q.cnt[0] != CNT_ONES |=>
      q.cnt[0] == $past(q.cnt[0]) + CNT_ONE)
      else $error("timer a did not advance by one on the tick");

   timer_hold_a: assert property (!q.tick && !pulse[0] && !q.wr_pend |=>
      $stable(q.cnt[0]))
      else $error("count a changed without a tick or event");

   event_inc_a: assert property (q.run[1] && q.evt[1] && pulse[1] && !q.wr_pend
      && q.cnt[1] != CNT_ONES |=> q.cnt[1] == $past(q.cnt[1]) + CNT_ONE)
      else $error("event counter b missed a counted edge");

   wrap_flag_a: assert property (timer_step_a_s ##0 q.cnt[0] == CNT_ONES |=>
      q.cnt[0] == CNT_RST && q.status[0])
      else $error("rollover of unit a did not wrap and flag");

   irq_follow_a: assert property ($rose(q.status[0]) && q.mask[0] |-> irq)
      else $error("unmasked flag did not raise the interrupt");

   capture_take_a: assert property (q.mode_c == MODE_CAPTURE && pulse[UNIT_C] |=>
      q.capt == $past(q.cnt[UNIT_C]) && q.status[CAPT_BIT])
      else $error("capture did not snapshot the count");

   reload_up_a: assert property ((q.mode_c == MODE_RELOAD || q.mode_c == MODE_OUTPUT)
      && !q.down_c && q.run[UNIT_C]
      && !q.evt[UNIT_C] && q.tick && !q.wr_pend && q.cnt[UNIT_C] == CNT_ONES |=>
      q.cnt[UNIT_C] == $past(q.reload) && q.status[UNIT_C])
      else $error("auto-reload did not load the reload value");

   tout_toggle_a: assert property ($past(q.mode_c) == MODE_OUTPUT
      && $rose(q.status[UNIT_C]) |-> q.tout != $past(q.tout))
      else $error("timer output did not toggle on rollover");

   // ------------------------------------------------------------------
   // Checks on unit c, event counter b, the flags and the stopped state
   // ------------------------------------------------------------------
   // Unit c steps on the tick unless software writes in that cycle
   sequence timer_step_c_s;
      q.tick && q.run[UNIT_C] && !q.wr_pend;
   endsequence

   // Reload and output modes share one counting path
   sequence reload_zone_s;
      (q.mode_c == MODE_RELOAD || q.mode_c == MODE_OUTPUT) && !q.evt[UNIT_C];
   endsequence

   // Address phase of a status read, which clears the flags
   sequence status_read_s;
      hsel && htrans[1] && hready && !hwrite && haddr == {24'h000000, STATUS_OFS};
   endsequence

   up_step_c_a: assert property (reload_zone_s ##0 timer_step_c_s
      ##0 (!q.down_c && q.cnt[UNIT_C] != CNT_ONES)
      |=> q.cnt[UNIT_C] == $past(q.cnt[UNIT_C]) + CNT_ONE)
      else $error("unit c did not count up by one");

   down_step_c_a: assert property (reload_zone_s ##0 timer_step_c_s
      ##0 (q.down_c && q.cnt[UNIT_C] != q.reload)
      |=> q.cnt[UNIT_C] == $past(q.cnt[UNIT_C]) - CNT_ONE)
      else $error("unit c did not count down by one");

   down_reload_a: assert property (reload_zone_s ##0 timer_step_c_s
      ##0 (q.down_c && q.cnt[UNIT_C] == q.reload)
      |=> q.cnt[UNIT_C] == CNT_ONES && q.status[UNIT_C])
      else $error("down count did not reload all ones and flag");

   tout_rollover_a: assert property ($changed(q.tout) |-> q.status[UNIT_C])
      else $error("timer output moved without a unit c rollover");

   capture_count_a: assert property (timer_step_c_s
      ##0 (q.mode_c == MODE_CAPTURE && q.cnt[UNIT_C] != CNT_ONES)
      |=> q.cnt[UNIT_C] == $past(q.cnt[UNIT_C]) + CNT_ONE)
      else $error("capture mode did not time machine cycles");

   capture_hold_a: assert property (q.mode_c != MODE_CAPTURE |=> $stable(q.capt))
      else $error("capture register moved outside capture mode");

   event_hold_a: assert property (q.evt[1] && !pulse[1] && !q.wr_pend |=>
      $stable(q.cnt[1]))
      else $error("event counter b moved without a counted edge");

   wrap_cause_a: assert property ($rose(q.status[0]) |-> $past(q.cnt[0]) == CNT_ONES)
      else $error("overflow flag of unit a without a rollover");

   flag_sticky_a: assert property (q.status[0]
      && !(hsel && htrans[1] && hready && !hwrite && haddr == {24'h000000, STATUS_OFS})
      |=> q.status[0])
      else $error("overflow flag of unit a dropped without a status read");

   read_clear_a: assert property (status_read_s ##0 (!q.tick && !(|pulse)) |=>
      q.status == '0)
      else $error("status read did not clear the flags");

   stop_hold_a: assert property (!q.run[UNIT_C] && !q.wr_pend |=> $stable(q.cnt[UNIT_C]))
      else $error("stopped unit c changed its count");

endmodule
`default_nettype wire

/* File: test/event_source.sv */
// Behavioural event source driving the three counter input pins
`timescale 1ns/1ps
`default_nettype none
module event_source (
   input wire logic hclk,
   output logic [2:0] pins
);
   // Pins idle high, so reset release brings no edge
   initial pins = 3'b111;

   // ------------------------------------------------------------
   // Falling edges on one pin
   // ------------------------------------------------------------
   // Each level is held 20 clocks, more than one machine cycle plus sync delay
   task automatic falls(input int unit, input int n);
      for (int i = 0; i < n; i++) begin
         repeat (20) @(posedge hclk);
         pins[unit] <= 1'b0;
         repeat (20) @(posedge hclk);
         pins[unit] <= 1'b1;
      end
   endtask
endmodule
`default_nettype wire

/* File: test/general_purpose_timer_counters_bench.sv */
// Self-checking bench for the three timer/counter units
`timescale 1ns/1ps
`default_nettype none
module general_purpose_timer_counters_bench import tc_pkg::*;;
   logic hclk = 1'b0;
   logic hresetn, hsel, hwrite, hreadyout, hresp, timer_out, irq;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize, pins;
   int n_mismatch = 0;
   int cmp_count = 0;

   always #5 hclk = ~hclk;

   timer_counters i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .event_input_a(pins[0]), .event_input_b(pins[1]), .event_input_c(pins[2]),
      .timer_out(timer_out), .irq(irq));

   event_source i_src (.hclk(hclk), .pins(pins));

   // ------------------------------------------------------------
   // Reporting
   // ------------------------------------------------------------
   task automatic results;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %0t %s: got %h want %h", $time, what, seen, exp);
      end
   endtask

   // ------------------------------------------------------------
   // Bus master
   // ------------------------------------------------------------
   // Bounded wait so a stuck slave ends the run instead of hanging it
   task automatic wait_ready;
      int i;
      i = 0;
      do begin
         @(posedge hclk);
         i++;
      end while (hreadyout !== 1'b1 && i < 64);
      if (i >= 64) begin
         n_mismatch++;
         results();
      end
   endtask

   // Entered just after an edge; address phase, then data phase
   task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= {24'h000000, ofs};
      hwrite <= wr;
      htrans <= 2'h2;
      wait_ready();
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
   endtask

   task automatic wreg(input logic [7:0] ofs, input logic [31:0] d);
      bus(1'b1, ofs, d);
   endtask

   task automatic rreg(input logic [7:0] ofs);
      bus(1'b0, ofs, 32'h00000000);
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   // Reset values, including unmapped words past the map
   task automatic s_reset;
      check(irq, 32'h0, "irq at reset");
      check(timer_out, 32'h0, "output at reset");
      check(hresp, 32'h0, "response okay");
      check(hreadyout, 32'h1, "ready always");
      wreg(8'h40, 32'hFFFFFFFF);
      for (int k = 0; k < 10; k++) begin
         rreg(8'(k * 4));
         check(rd, 32'h0, "reset or unmapped read");
      end
   endtask

   // Unit a as timer, unit b as counter with a quiet pin
   task automatic s_timer;
      logic [31:0] first;
      wreg(CTRL_OFS, (32'h3 << RUN_LSB) | (32'h2 << EVT_LSB));
      rreg(COUNT_A_OFS);
      first = rd;
      repeat (118) @(posedge hclk);
      rreg(COUNT_A_OFS);
      check(rd, first + 32'hA, "ten machine cycles");
      rreg(COUNT_B_OFS);
      check(rd, 32'h0, "counter ignores machine cycles");
   endtask

   // Five edges at a legal rate on unit b
   task automatic s_counter;
      i_src.falls(1, 5);
      repeat (30) @(posedge hclk);
      rreg(COUNT_B_OFS);
      check(rd, 32'h5, "edge count");
      wreg(CTRL_OFS, (32'h3 << RUN_LSB) | (32'h3 << EVT_LSB));
      wreg(COUNT_A_OFS, 32'h0);
      i_src.falls(0, 2);
      repeat (30) @(posedge hclk);
      rreg(COUNT_A_OFS);
      check(rd, 32'h2, "unit a edge count");
      wreg(CTRL_OFS, 32'h0);
   endtask

   // Rollover of unit a with its interrupt unmasked
   task automatic s_overflow;
      wreg(MASK_OFS, 32'h1);
      wreg(COUNT_A_OFS, 32'h0000FFFE);
      wreg(CTRL_OFS, 32'h1);
      repeat (40) @(posedge hclk);
      check(irq, 32'h1, "overflow interrupt");
      rreg(STATUS_OFS);
      check(rd, 32'h1, "overflow flag");
      rreg(COUNT_A_OFS);
      check(rd[31:4], 32'h0, "wrap to zero");
      check(irq, 32'h0, "flag cleared by read");
      wreg(CTRL_OFS, 32'h0);
   endtask

   // Unit c output generator, then reload counting down
   task automatic s_output;
      wreg(RELOAD_OFS, 32'h0000FFF0);
      wreg(COUNT_C_OFS, 32'h0000FFFE);
      wreg(CTRL_OFS, 32'h4 | (32'(MODE_OUTPUT) << MODE_LSB));
      repeat (40) @(posedge hclk);
      check(timer_out, 32'h1, "output toggled");
      check(irq, 32'h0, "masked flag");
      rreg(STATUS_OFS);
      check(rd, 32'h4, "unit c flag");
      rreg(COUNT_C_OFS);
      check(rd[31:4], 32'hFFF, "reloaded count");
      wreg(CTRL_OFS, 32'h0);
      wreg(COUNT_C_OFS, 32'h0000FFF2);
      wreg(CTRL_OFS, 32'h4 | (32'(MODE_RELOAD) << MODE_LSB) | (32'h1 << DOWN_BIT));
      repeat (50) @(posedge hclk);
      rreg(STATUS_OFS);
      check(rd, 32'h4, "down reload flag");
      rreg(COUNT_C_OFS);
      check(rd[31:4], 32'hFFF, "down reload count");
   endtask

   // Capture of the running count on one edge of pin c
   task automatic s_capture;
      wreg(CTRL_OFS, 32'h0);
      rreg(STATUS_OFS);
      wreg(COUNT_C_OFS, 32'h0);
      wreg(CTRL_OFS, 32'h4 | (32'(MODE_CAPTURE) << MODE_LSB));
      repeat (100) @(posedge hclk);
      i_src.falls(2, 1);
      repeat (30) @(posedge hclk);
      rreg(CAPTURE_OFS);
      check(32'(rd > 32'h5 && rd < 32'h14), 32'h1, "captured count");
      rreg(STATUS_OFS);
      check(rd, 32'h8, "capture flag");
      wreg(CTRL_OFS, 32'h4 | (32'h4 << EVT_LSB));
      wreg(COUNT_C_OFS, 32'h0);
      i_src.falls(2, 2);
      repeat (30) @(posedge hclk);
      rreg(COUNT_C_OFS);
      check(rd, 32'h2, "unit c event count");
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      s_reset();
      s_timer();
      s_counter();
      s_overflow();
      s_output();
      s_capture();
      results();
   end
endmodule
`default_nettype wire
